// file: common/tcbd_pkg.sv
/*
  Constants and types for the six-channel touch baseline/detect back end.
  Assumes a 100 MHz mclk and one digitized burst result per channel per cycle.
*/
package tcbd_pkg;
  localparam int NUM_CH = 6;
  localparam int CH_W = 3;
  localparam int WORD_W = 16;
  localparam int TMR_W = 12;
  localparam int DRIFT_W = 8;
  localparam int INTEG_W = 2;
  // Detection levels, counts above reference
  localparam logic [WORD_W-1:0] THRESH = 16'h0006;
  localparam logic [WORD_W-1:0] HYST = 16'h0002;
  localparam logic [INTEG_W-1:0] INTEG_CNT = 2'h3;
  // Drift defaults: step size in counts, intervals in bursts per step
  localparam logic [WORD_W-1:0] DRIFT_STEP = 16'h0001;
  localparam logic [DRIFT_W-1:0] RISE_BURSTS = 8'h40;
  localparam logic [DRIFT_W-1:0] FALL_BURSTS = 8'h04;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CYCLE_MS = 33;
  localparam int MAXON_SHORT_S = 10;
  localparam int MAXON_LONG_S = 60;
  localparam int unsigned SLOT_CYCLES = CYCLE_MS * 1000 * CLK_MHZ;
  localparam logic [TMR_W-1:0] TICKS_SHORT = TMR_W'(MAXON_SHORT_S * 1000 / CYCLE_MS);
  localparam logic [TMR_W-1:0] TICKS_LONG = TMR_W'(MAXON_LONG_S * 1000 / CYCLE_MS);
  localparam logic [TMR_W-1:0] TMR_MAX = 12'hfff;
  localparam logic [NUM_CH-1:0] ALL_CH = 6'h3f;
  typedef logic [WORD_W-1:0] tcbd_word_t;
  typedef enum logic [1:0] {TCBD_CAL, TCBD_TRACK, TCBD_DETECT} tcbd_state_t;
endpackage

// file: common/tcbd_tick_if.sv
/*
  Carrier between the timebase and the channel processor.
  Assumes both ends run on mclk.
*/
`timescale 1ns/10ps
interface tcbd_tick_if;
  import tcbd_pkg::*;
  logic acq_tick;
  logic cycle_done;
  logic toggle_mode;
  logic timeout_inf;
  logic [TMR_W-1:0] timeout_ticks;
  modport src (output acq_tick, toggle_mode, timeout_inf, timeout_ticks, input cycle_done);
  modport snk (input acq_tick, toggle_mode, timeout_inf, timeout_ticks, output cycle_done);
endinterface

// file: hw/tcbd_timebase.sv
/*
  Acquisition-cycle timebase and strap option decoder.
  Assumes straps are asynchronous pins and cycle_done marks the last burst.
*/
`timescale 1ns/10ps
module tcbd_timebase #(
  parameter int unsigned SLOT_CYCLES = tcbd_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Strap pins
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  // Toward channel processor
  tcbd_tick_if.src tb
);
  import tcbd_pkg::*;
  localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);
  logic [2:0] sa_q, sb_q;
  logic strap_a_q, strap_b_q, loaded_q;
  logic [SLOT_W-1:0] slot_q;
  logic slot_done;

  // Three-stage strap synchronisers, accept when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sa_q <= 3'h0;
      sb_q <= 3'h0;
      strap_a_q <= 1'b0;
      strap_b_q <= 1'b0;
    end else begin
      sa_q <= {sa_q[1:0], option_strap_a};
      sb_q <= {sb_q[1:0], option_strap_b};
      if (sa_q[1] == sa_q[2]) strap_a_q <= sa_q[2];
      if (sb_q[1] == sb_q[2]) strap_b_q <= sb_q[2];
    end
  end

  // Least cycle length counted from mclk; long bursts stretch the tick
  assign slot_done = (slot_q == '0);
  assign tb.acq_tick = tb.cycle_done && slot_done;
  always_ff @(posedge mclk) begin
    if (!rst_b) slot_q <= SLOT_W'(SLOT_CYCLES - 1);
    else if (tb.acq_tick) slot_q <= SLOT_W'(SLOT_CYCLES - 1);
    else if (!slot_done) slot_q <= slot_q - 1'b1;
  end

  // Options sampled once per acquisition cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      loaded_q <= 1'b0;
      tb.toggle_mode <= 1'b0;
      tb.timeout_inf <= 1'b1;
      tb.timeout_ticks <= TICKS_SHORT;
    end else if (tb.acq_tick || !loaded_q) begin
      loaded_q <= 1'b1;
      tb.toggle_mode <= strap_a_q && strap_b_q;
      tb.timeout_inf <= !strap_a_q && !strap_b_q;
      tb.timeout_ticks <= (strap_a_q && !strap_b_q) ? TICKS_LONG : TICKS_SHORT;
    end
  end

  a_slot_reload: assert property (@(posedge mclk) disable iff (!rst_b)
    tb.acq_tick |=> slot_q == SLOT_W'(SLOT_CYCLES - 1))
    else $error("slot counter not reloaded after tick");
  a_mode_decode: assert property (@(posedge mclk) disable iff (!rst_b)
    tb.acq_tick && strap_a_q && !strap_b_q |=> !tb.toggle_mode && !tb.timeout_inf
      && tb.timeout_ticks == TICKS_LONG)
    else $error("strap decode wrong for long timeout");
  c_tick: cover property (@(posedge mclk) disable iff (!rst_b) tb.acq_tick);
endmodule // tcbd_timebase

// file: hw/tcbd_detect.sv
/*
  Six-channel touch baseline tracking, detection and max on-duration logic.
  Assumes burst results arrive one channel at a time, channel 5 last.
*/
`timescale 1ns/10ps
module tcbd_detect #(
  parameter int unsigned SLOT_CYCLES = tcbd_pkg::SLOT_CYCLES,
  parameter tcbd_pkg::tcbd_word_t STEP = tcbd_pkg::DRIFT_STEP,
  parameter logic [tcbd_pkg::DRIFT_W-1:0] RISE_INT = tcbd_pkg::RISE_BURSTS,
  parameter logic [tcbd_pkg::DRIFT_W-1:0] FALL_INT = tcbd_pkg::FALL_BURSTS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Burst results
  input wire logic meas_valid,
  input wire logic [tcbd_pkg::CH_W-1:0] meas_chan,
  input wire tcbd_pkg::tcbd_word_t meas_value,
  // Burst in progress
  input wire logic burst_active,
  input wire logic [tcbd_pkg::CH_W-1:0] burst_chan,
  // Strap pins
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  // Outputs
  output logic [tcbd_pkg::NUM_CH-1:0] key_out,
  output logic [tcbd_pkg::NUM_CH-1:0] sense_clamp
);
  import tcbd_pkg::*;

  tcbd_tick_if tb ();
  tcbd_word_t ref_q [NUM_CH];
  tcbd_state_t st_q [NUM_CH];
  logic [INTEG_W-1:0] integ_q [NUM_CH];
  logic [DRIFT_W-1:0] dcnt_q [NUM_CH];
  logic [TMR_W-1:0] tmr_q [NUM_CH];
  logic [NUM_CH-1:0] out_q;
  logic [NUM_CH-1:0] clamp_q;

  // Selected-channel working values
  logic upd, det_now, tmo, recal, drift_en;
  logic [CH_W-1:0] idx;
  tcbd_word_t sig, ref_c, hi_lvl, lo_lvl, ref_d;
  tcbd_state_t st_c, st_d;
  logic [INTEG_W-1:0] integ_c, integ_d;
  logic [DRIFT_W-1:0] dcnt_c, dcnt_d;
  logic out_d;

  // Saturating 16-bit add
  function automatic tcbd_word_t sat_add(input tcbd_word_t a, input tcbd_word_t b);
    logic [WORD_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[WORD_W] ? '1 : s[WORD_W-1:0];
  endfunction

  // One slew-limited step of the reference toward the signal
  function automatic tcbd_word_t step_to(input tcbd_word_t r, input tcbd_word_t s,
                                         input logic up);
    tcbd_word_t gap;
    gap = up ? s - r : r - s;
    if (gap < STEP) return s;
    return up ? r + STEP : r - STEP;
  endfunction

  tcbd_timebase #(.SLOT_CYCLES(SLOT_CYCLES)) u_timebase (
    .mclk(mclk),
    .rst_b(rst_b),
    .option_strap_a(option_strap_a),
    .option_strap_b(option_strap_b),
    .tb(tb.src)
  );

  assign upd = meas_valid && (meas_chan < CH_W'(NUM_CH));
  assign idx = upd ? meas_chan : '0;
  assign tb.cycle_done = meas_valid && (meas_chan == CH_W'(NUM_CH - 1));

  // Levels and decision for the channel being reported
  always_comb begin
    sig = meas_value;
    ref_c = ref_q[idx];
    st_c = st_q[idx];
    integ_c = integ_q[idx];
    dcnt_c = dcnt_q[idx];
    hi_lvl = sat_add(ref_c, THRESH);
    lo_lvl = sat_add(ref_c, THRESH - HYST);
    det_now = (st_c == TCBD_DETECT) ? (sig >= lo_lvl) : (sig > hi_lvl);
    tmo = (st_c == TCBD_DETECT) && !tb.timeout_inf && (tmr_q[idx] >= tb.timeout_ticks);
    recal = (st_c == TCBD_CAL) || tmo;
    drift_en = (st_c == TCBD_TRACK) && !det_now;
  end

  // Next state of the selected channel
  always_comb begin
    st_d = st_c;
    integ_d = integ_c;
    if (recal) begin
      st_d = TCBD_TRACK;
      integ_d = '0;
    end else if (!det_now) begin
      st_d = TCBD_TRACK;
      integ_d = '0;
    end else if (integ_c != INTEG_CNT) begin
      integ_d = integ_c + 1'b1;
      if (integ_c == INTEG_CNT - 1'b1) st_d = TCBD_DETECT;
    end
  end

  // Asymmetric drift toward the raw signal
  always_comb begin
    ref_d = ref_c;
    dcnt_d = '0;
    if (recal) begin
      ref_d = sig;
    end else if (drift_en && sig > ref_c) begin
      if (dcnt_c >= RISE_INT - 1'b1) ref_d = step_to(ref_c, sig, 1'b1);
      else dcnt_d = dcnt_c + 1'b1;
    end else if (drift_en && sig < ref_c) begin
      if (dcnt_c >= FALL_INT - 1'b1) ref_d = step_to(ref_c, sig, 1'b0);
      else dcnt_d = dcnt_c + 1'b1;
    end
  end

  // Output per mode
  always_comb begin
    if (tb.toggle_mode) begin
      out_d = out_q[idx] ^ (st_d == TCBD_DETECT && st_c != TCBD_DETECT);
    end else begin
      out_d = (st_d == TCBD_DETECT);
    end
  end

  // Per-channel reference, drift and detection state; only the reported channel moves
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ref_q[c] <= '0;
        st_q[c] <= TCBD_CAL;
        integ_q[c] <= '0;
        dcnt_q[c] <= '0;
      end
    end else if (upd) begin
      ref_q[idx] <= ref_d;
      st_q[idx] <= st_d;
      integ_q[idx] <= integ_d;
      dcnt_q[idx] <= dcnt_d;
    end
  end

  // Max on-duration timers count acquisition ticks while detecting
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int c = 0; c < NUM_CH; c++) tmr_q[c] <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (st_q[c] != TCBD_DETECT) tmr_q[c] <= '0;
        else if (tb.acq_tick && tmr_q[c] != TMR_MAX) tmr_q[c] <= tmr_q[c] + 1'b1;
      end
    end
  end

  // Output latches
  always_ff @(posedge mclk) begin
    if (!rst_b) out_q <= '0;
    else if (upd) out_q[idx] <= out_d;
  end

  // During a burst, ground every electrode except the one under measurement; release all between bursts
  always_ff @(posedge mclk) begin
    if (!rst_b) clamp_q <= '0;
    else if (burst_active) clamp_q <= ~(6'h01 << burst_chan) & ALL_CH;
    else clamp_q <= '0;
  end

  assign key_out = out_q;
  assign sense_clamp = clamp_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_clamp_others: assert property (
    burst_active |=> sense_clamp == (~(6'h01 << $past(burst_chan)) & ALL_CH))
    else $error("clamp pattern wrong during burst");
  a_third_detect: assert property (
    upd && !recal && st_c == TCBD_TRACK && integ_c == 2'h2 && sig > hi_lvl
      |=> st_q[$past(idx)] == TCBD_DETECT)
    else $error("third detection did not enter detect");
  a_integ_clear: assert property (
    upd && !det_now |=> integ_q[$past(idx)] == '0)
    else $error("integrator not cleared on missed burst");
  a_hyst_hold: assert property (
    upd && !tmo && st_c == TCBD_DETECT && sig >= sat_add(ref_c, 16'h0004)
      |=> st_q[$past(idx)] == TCBD_DETECT)
    else $error("released above hysteresis level");
  a_ref_frozen: assert property (
    upd && !tmo && st_c == TCBD_DETECT |=> ref_q[$past(idx)] == $past(ref_c))
    else $error("reference moved during detection");
  a_recal_load: assert property (
    upd && recal |=> ref_q[$past(idx)] == $past(meas_value) && integ_q[$past(idx)] == '0)
    else $error("recalibration did not reload reference");
  a_direct_off: assert property (
    upd && tmo && !tb.toggle_mode |=> !key_out[$past(idx)])
    else $error("direct output stayed on after timeout");
  a_toggle_keep: assert property (
    upd && tmo && tb.toggle_mode |=> key_out == $past(key_out))
    else $error("toggle output changed on timeout");
  a_drift_slew: assert property (
    upd && !recal |=> (ref_q[$past(idx)] - $past(ref_c) <= STEP)
      || ($past(ref_c) - ref_q[$past(idx)] <= STEP))
    else $error("reference moved more than one step");
  a_timer_reset: assert property (
    upd && tmo |=> ##1 tmr_q[$past(idx, 2)] == '0)
    else $error("timer not cleared after timeout");

  c_detect_entry: cover property (upd && st_c != TCBD_DETECT && st_d == TCBD_DETECT);
  c_timeout: cover property (upd && tmo);
  c_toggle_flip: cover property (upd && tb.toggle_mode && out_d != out_q[idx]);
  c_drift_down: cover property (upd && drift_en && ref_d < ref_c);
endmodule // tcbd_detect

// file: tb/tcbd_electrode_model.sv
/*
  Model of six electrodes with their sample capacitors and burst converter.
  Assumes start is raised by the bench while busy is low.
*/
`timescale 1ns/10ps
module tcbd_electrode_model (
  // Clock and control
  input wire logic mclk,
  input wire logic start,
  input wire logic slow,
  input wire logic [5:0][15:0] level,
  // Toward the sensor block
  output logic meas_valid,
  output logic [2:0] meas_chan,
  output tcbd_pkg::tcbd_word_t meas_value,
  output logic burst_active,
  output logic [2:0] burst_chan,
  output logic busy
);
  import tcbd_pkg::*;
  logic go_s = 1'b0;
  logic [2:0] ph = 3'h0;
  // Idle lines at time zero
  initial begin
    meas_valid = 1'b0;
    meas_chan = 3'h0;
    meas_value = 16'h0000;
    burst_active = 1'b0;
    burst_chan = 3'h0;
    busy = 1'b0;
  end
  // Start request taken at the rising edge
  always @(posedge mclk) go_s <= start;
  // One acquisition: each channel bursts in turn, a result after each
  always @(negedge mclk) begin
    meas_valid <= 1'b0;
    if (meas_valid) begin
      meas_value <= ~meas_value;  // Released lines lose the old value
      meas_chan <= ~meas_chan;
    end
    if (!busy) begin
      if (go_s) begin
        busy <= 1'b1;
        burst_active <= 1'b1;
        burst_chan <= 3'h0;
        ph <= 3'h0;
      end
    end else if (burst_active) begin
      if (ph >= (slow ? 3'h4 : 3'h1)) begin
        burst_active <= 1'b0;
        meas_valid <= 1'b1;
        meas_chan <= burst_chan;
        meas_value <= level[burst_chan];
      end else ph <= ph + 3'h1;
    end else if (burst_chan == 3'h5) busy <= 1'b0;
    else begin
      burst_chan <= burst_chan + 3'h1;
      burst_active <= 1'b1;
      ph <= 3'h0;
    end
  end
endmodule // tcbd_electrode_model

// file: tb/tcbd_detect_tb.sv
/*
  Self-checking bench for the touch detect block.
  Assumes the electrode model supplies bursts and results.
*/
`timescale 1ns/10ps
module tcbd_detect_tb;
  import tcbd_pkg::*;
  logic mclk = 0, rst_b = 0, strap_a = 0, strap_b = 0, start = 0, slow = 0;
  logic mv, ba, busy, armed = 0, rst_s = 0, ba_s = 0, mv_s = 0;
  logic [2:0] mc, bc, bc_s, mc_s;
  logic [5:0][15:0] lvl;
  logic [5:0] key_out, sense_clamp, cl_e;
  logic [5:0] exp_q [$];
  tcbd_word_t mval;
  tcbd_word_t base [6];
  int n_fail = 0, checks_done = 0, drop;
  logic [31:0] rs = 32'h1072e88d;
  // Clock
  initial forever #5 mclk = ~mclk;
  tcbd_detect #(.SLOT_CYCLES(16)) u_dut (.mclk(mclk), .rst_b(rst_b), .meas_valid(mv),
    .meas_chan(mc), .meas_value(mval), .burst_active(ba), .burst_chan(bc),
    .option_strap_a(strap_a), .option_strap_b(strap_b), .key_out(key_out),
    .sense_clamp(sense_clamp));
  tcbd_electrode_model u_elec (.mclk(mclk), .start(start), .slow(slow), .level(lvl),
    .meas_valid(mv), .meas_chan(mc), .meas_value(mval), .burst_active(ba),
    .burst_chan(bc), .busy(busy));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One acquisition cycle, noting the key state expected at its end
  task automatic acq(logic [5:0] ek, bit note);
    if (note) exp_q.push_back(ek);
    slow = ((xs() & 32'h3) == 32'h0);
    start = 1;
    repeat (2) @(negedge mclk);
    start = 0;
    while (busy) @(negedge mclk);
  endtask
  // Reset with given straps, then one calibrating cycle
  task automatic do_reset(logic a, logic b);
    rst_b = 0;
    strap_a = a;
    strap_b = b;
    repeat (5) @(negedge mclk);
    chk("key_out_rst", 16'(key_out), 16'h0000);
    rst_b = 1;
    for (int c = 0; c < 6; c++) lvl[c] = base[c];
    acq(6'h00, 1);
  endtask
  // Three bursts at one level
  task automatic hit(int ch, tcbd_word_t v, logic [5:0] e0, logic [5:0] e1);
    lvl[ch] = v;
    acq(e0, 1);
    acq(e0, 1);
    acq(e1, 1);
  endtask
  // Hold levels, recording the cycle at which a key drops
  task automatic hold(int ch, int n);
    drop = 0;
    for (int i = 1; i <= n; i++) begin
      acq(6'h00, 0);
      if (drop == 0 && i > 5 && key_out[ch] === 1'b0) drop = i;
    end
  endtask
  // Sample what the design sees at its edge
  always @(posedge mclk) begin
    if (!rst_b) armed <= 1'b1;
    rst_s <= rst_b;
    ba_s <= ba;
    bc_s <= bc;
    mv_s <= mv;
    mc_s <= mc;
  end
  assign cl_e = (rst_s && ba_s) ? (ALL_CH & ~(6'h01 << bc_s)) : 6'h00;
  // Compare once the design has updated
  always @(negedge mclk) begin
    if (armed) chk("sense_clamp", 16'(sense_clamp), 16'(cl_e));
    if (mv_s && mc_s == 3'h5 && exp_q.size() > 0) begin
      chk("key_out", 16'(key_out), 16'(exp_q.pop_front()));
    end
  end
  // Cut a hang short
  initial begin
    repeat (95000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  // Main sequence
  initial begin
    for (int c = 0; c < 6; c++) base[c] = 16'h0800 + 16'(xs() & 32'h3ff);
    // Direct output, no timeout
    do_reset(1'b0, 1'b0);
    lvl[1] = base[1] + 16'h0006;
    repeat (4) acq(6'h00, 1);
    lvl[1] = base[1] + 16'h0007;
    repeat (2) acq(6'h00, 1);
    lvl[1] = base[1] + 16'h0006;
    acq(6'h00, 1);
    hit(1, base[1] + 16'h0007, 6'h00, 6'h02);
    lvl[1] = base[1] + 16'h0014;
    repeat (350) acq(6'h02, 1);
    lvl[1] = base[1] + 16'h0004;
    acq(6'h02, 1);
    lvl[1] = base[1] + 16'h0003;
    acq(6'h00, 1);
    lvl[1] = base[1] + 16'h0005;
    repeat (40) acq(6'h00, 1);
    hit(1, base[1] + 16'h0007, 6'h00, 6'h02);
    lvl[1] = base[1] - 16'h000a;
    repeat (60) acq(6'h00, 1);
    hit(1, base[1] - 16'h0003, 6'h00, 6'h02);
    // Direct output, short timeout, neighbour held meanwhile
    do_reset(1'b0, 1'b1);
    lvl[1] = base[1] + 16'h000a;
    hold(1, 50);
    lvl[3] = base[3] + 16'h000a;
    hold(1, 280);
    chk("drop_short", 16'(drop >= 253 && drop <= 262), 16'h0001);
    chk("key_after_recal", 16'(key_out), 16'h0008);
    hit(1, base[1] + 16'h0011, 6'h08, 6'h0a);
    // Toggle output
    do_reset(1'b1, 1'b1);
    hit(0, base[0] + 16'h000a, 6'h00, 6'h01);
    lvl[0] = base[0];
    acq(6'h01, 1);
    hit(0, base[0] + 16'h000a, 6'h01, 6'h00);
    lvl[0] = base[0];
    acq(6'h00, 1);
    hit(0, base[0] + 16'h000a, 6'h00, 6'h01);
    hold(0, 330);
    chk("toggle_kept", 16'(key_out), 16'h0001);
    hit(0, base[0] + 16'h0011, 6'h01, 6'h00);
    // Direct output, long timeout
    do_reset(1'b1, 1'b0);
    lvl[2] = base[2] + 16'h000a;
    hold(2, 1830);
    chk("drop_long", 16'(drop >= 1818 && drop <= 1827), 16'h0001);
    give_verdict();
  end
endmodule // tcbd_detect_tb
